// ---- rtl/spims_defs.vh ----
// constants for the byte-wide serial master/slave port
`ifndef SPIMS_DEFS_VH
`define SPIMS_DEFS_VH

// register indexes; byte address is four times the index
`define SPIMS_CTRL_IDX 6'h0A
`define SPIMS_STAT_IDX 6'h0B
`define SPIMS_DATA_IDX 6'h0C

// decoded register selects
`define SPIMS_SEL_NONE 2'h0
`define SPIMS_SEL_CTRL 2'h1
`define SPIMS_SEL_STAT 2'h2
`define SPIMS_SEL_DATA 2'h3

// control register field positions
`define SPIMS_C_IRQ_EN 7
`define SPIMS_C_PORT_EN 6
`define SPIMS_C_MASTER 4
`define SPIMS_C_CLOCK_POLARITY_BIT 3
`define SPIMS_C_CLOCK_PHASE_BIT 2
`define SPIMS_C_RATE_HI 1
`define SPIMS_C_RATE_LO 0

// status register field positions
`define SPIMS_S_DONE 7
`define SPIMS_S_WRITE_COLLISION_FLAG 6
`define SPIMS_S_MODE_FAULT_FLAG 4

// reset values
`define SPIMS_CTRL_RST 8'h00
`define SPIMS_BYTE_RST 8'h00

// bits in one transfer, last bit counter value
`define SPIMS_LAST_BIT 3'h7

// rate codes 00/01/10/11 divide pclk by 2/4/16/32;
// terminal counts of one half period of the serial clock
`define SPIMS_HALF_DIV2 4'h0
`define SPIMS_HALF_DIV4 4'h1
`define SPIMS_HALF_DIV16 4'h7
`define SPIMS_HALF_DIV32 4'hF

`endif

// ---- rtl/spims_rate_div.v ----
// half-period tick generator for the master serial clock
`timescale 1ns/1ns
`include "spims_defs.vh"

module spims_rate_div #(
    parameter CW = 4
) (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // control
    input wire run,
    input wire [1:0] rate,
    // half-period strobe
    output wire tick
);

    reg [CW-1:0] cnt_ff; // pclk cycles in this half period
    reg [CW-1:0] term; // terminal count for chosen rate

    // terminal count per rate code
    always @* begin
        case (rate)
            2'h0: term = `SPIMS_HALF_DIV2;
            2'h1: term = `SPIMS_HALF_DIV4;
            2'h2: term = `SPIMS_HALF_DIV16;
            2'h3: term = `SPIMS_HALF_DIV32;
            default: term = `SPIMS_HALF_DIV2;
        endcase
    end

    assign tick = run & (cnt_ff == term);

    // counter restarts whenever the clock is idle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= {CW{1'h0}};
        end else if (!run || tick) begin
            cnt_ff <= {CW{1'h0}};
        end else begin
            cnt_ff <= cnt_ff + {{(CW-1){1'h0}}, 1'h1};
        end
    end

endmodule // spims_rate_div

// ---- rtl/spims_top.v ----
// byte-wide serial master/slave port with apb registers
`timescale 1ns/1ns
`include "spims_defs.vh"

module spims_top #(
    parameter AW = 8
) (
    // apb clock and reset
    input wire pclk,
    input wire presetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    // slave select input
    input wire ss_n,
    // serial clock pin
    input wire sck_in,
    output wire sck_out,
    output wire sck_oe,
    // master-out data pin
    input wire mosi_in,
    output wire mosi_out,
    output wire mosi_oe,
    // master-in data pin
    input wire miso_in,
    output wire miso_out,
    output wire miso_oe,
    // interrupt request
    output wire irq
);

    // map a bus address onto one of the three registers
    function [1:0] reg_sel;
        input [AW-1:0] addr;
        begin
            reg_sel = `SPIMS_SEL_NONE;
            if (addr[1:0] == 2'h0) begin
                case (addr[7:2])
                    `SPIMS_CTRL_IDX: reg_sel = `SPIMS_SEL_CTRL;
                    `SPIMS_STAT_IDX: reg_sel = `SPIMS_SEL_STAT;
                    `SPIMS_DATA_IDX: reg_sel = `SPIMS_SEL_DATA;
                    default: reg_sel = `SPIMS_SEL_NONE;
                endcase
            end
        end
    endfunction

    // control register fields
    reg irq_en_ff; // interrupt enable
    reg port_en_ff; // port enable
    reg master_ff; // master select
    reg clock_polarity_bit_ff; // idle clock level
    reg clock_phase_bit_ff; // clock phase
    reg [1:0] rate_ff; // master rate select

    // status flags and clearing-sequence arms
    reg done_ff; // transfer done flag
    reg write_collision_flag_ff; // write collision flag
    reg mode_fault_flag_ff; // mode fault flag
    reg stat_seen_ff; // status read while done/write_collision_flag set
    reg mode_fault_flag_seen_ff; // status read while mode_fault_flag set

    // transfer engine
    reg [7:0] shr_ff; // shift register
    reg [7:0] rbuf_ff; // received byte buffer
    reg out_ff; // bit on the outgoing data line
    reg busy_ff; // byte in progress
    reg [2:0] cnt_ff; // completed bit cycles
    reg sck_ff; // generated master clock
    reg sck_prev_ff; // last sampled slave clock
    reg [31:0] prdata_ff; // read data for access phase

    // bus decode
    wire [1:0] sel; // addressed register
    wire acc; // access phase of a mapped transfer
    wire wr_acc; // write access
    wire rd_acc; // read access
    wire ctrl_wr; // control write
    wire stat_rd; // status read
    wire data_acc; // data read or write
    wire data_wr; // data write

    // mode and edges
    wire mst_on; // enabled master
    wire slv_on; // enabled and selected slave
    wire fault; // another master pulls select low
    wire tick; // half period of master clock
    wire run; // master clock running
    wire din; // incoming data bit
    wire m_lead; // master leading clock edge
    wire m_trail; // master trailing clock edge
    wire s_lead; // slave leading clock edge
    wire s_trail; // slave trailing clock edge
    wire lead; // leading edge either mode
    wire trail; // trailing edge either mode
    wire samp; // capture incoming bit
    wire shift; // drive next outgoing bit
    wire last; // end of eighth bit cycle
    wire collide; // data write during a transfer
    wire inhibit; // data write held off by done flag
    wire load; // accepted data write
    wire [7:0] rx_byte; // byte to place in read buffer

    assign sel = reg_sel(paddr);
    assign acc = psel & penable & (sel != `SPIMS_SEL_NONE);
    assign wr_acc = acc & pwrite;
    assign rd_acc = acc & ~pwrite;
    assign ctrl_wr = wr_acc & (sel == `SPIMS_SEL_CTRL);
    assign stat_rd = rd_acc & (sel == `SPIMS_SEL_STAT);
    assign data_acc = acc & (sel == `SPIMS_SEL_DATA);
    assign data_wr = data_acc & pwrite;

    // zero wait states; unmapped addresses answer with an error
    assign pready = 1'h1;
    assign pslverr = psel & penable & (sel == `SPIMS_SEL_NONE);
    assign prdata = prdata_ff;

    // master mode only while enabled; a low select while master is set is a fault
    assign mst_on = port_en_ff & master_ff;
    assign slv_on = port_en_ff & ~master_ff & ~ss_n;
    assign fault = master_ff & ~ss_n;

    // rate divider only runs in master mode
    assign run = mst_on & busy_ff;

    spims_rate_div #(
        .CW(4)
    ) u_rate_div (
        .pclk(pclk),
        .presetn(presetn),
        .run(run),
        .rate(rate_ff),
        .tick(tick)
    );

    // master samples the far slave, slave samples the master
    assign din = master_ff ? miso_in : mosi_in;

    // master edges come from its own divided clock
    assign m_lead = run & tick & (sck_ff == clock_polarity_bit_ff);
    assign m_trail = run & tick & (sck_ff != clock_polarity_bit_ff);

    // slave edges come from the pin, only while selected
    assign s_lead = slv_on & (sck_in != clock_polarity_bit_ff)
        & (sck_prev_ff == clock_polarity_bit_ff);
    assign s_trail = slv_on & (sck_in == clock_polarity_bit_ff)
        & (sck_prev_ff != clock_polarity_bit_ff);

    assign lead = m_lead | s_lead;
    assign trail = m_trail | s_trail;

    // phase picks which edge samples and which shifts
    assign samp = clock_phase_bit_ff ? trail : lead;
    assign shift = clock_phase_bit_ff ? lead : trail;

    // eighth trailing edge closes the byte
    assign last = trail & busy_ff & (cnt_ff == `SPIMS_LAST_BIT);

    // phase one samples on the closing edge, so fold that bit in
    assign rx_byte = clock_phase_bit_ff ? {shr_ff[6:0], din} : shr_ff;

    // writes during a byte, or to a selected phase-zero slave
    assign collide = data_wr & (busy_ff | (slv_on & ~clock_phase_bit_ff));
    // writes wait until status has been read after completion
    assign inhibit = done_ff & ~stat_seen_ff;
    assign load = data_wr & ~collide & ~inhibit & ~fault;

    // read data is captured in the setup phase
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            case (sel)
                `SPIMS_SEL_CTRL: begin
                    prdata_ff <= {24'h000000, irq_en_ff, port_en_ff,
                        1'h0, master_ff, clock_polarity_bit_ff, clock_phase_bit_ff, rate_ff};
                end
                `SPIMS_SEL_STAT: begin
                    prdata_ff <= {24'h000000, done_ff, write_collision_flag_ff,
                        1'h0, mode_fault_flag_ff, 4'h0};
                end
                `SPIMS_SEL_DATA: begin
                    prdata_ff <= {24'h000000, rbuf_ff};
                end
                default: begin
                    prdata_ff <= 32'h00000000;
                end
            endcase
        end
    end

    // control register; a mode fault overrides a write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_en_ff <= 1'h0;
            port_en_ff <= 1'h0;
            master_ff <= 1'h0;
            clock_polarity_bit_ff <= 1'h0;
            clock_phase_bit_ff <= 1'h0;
            rate_ff <= 2'h0;
        end else begin
            if (ctrl_wr) begin
                irq_en_ff <= pwdata[`SPIMS_C_IRQ_EN];
                port_en_ff <= pwdata[`SPIMS_C_PORT_EN];
                master_ff <= pwdata[`SPIMS_C_MASTER];
                clock_polarity_bit_ff <= pwdata[`SPIMS_C_CLOCK_POLARITY_BIT];
                clock_phase_bit_ff <= pwdata[`SPIMS_C_CLOCK_PHASE_BIT];
                rate_ff <= pwdata[`SPIMS_C_RATE_HI:`SPIMS_C_RATE_LO];
            end
            // fault: drop to slave and disconnect the pins
            if (fault) begin
                master_ff <= 1'h0;
                port_en_ff <= 1'h0;
            end
        end
    end

    // status flags; a new event wins over its clear
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_ff <= 1'h0;
            write_collision_flag_ff <= 1'h0;
            mode_fault_flag_ff <= 1'h0;
            stat_seen_ff <= 1'h0;
            mode_fault_flag_seen_ff <= 1'h0;
        end else begin
            // done: set at byte end, cleared by status then data
            if (last) begin
                done_ff <= 1'h1;
            end else if (data_acc && stat_seen_ff) begin
                done_ff <= 1'h0;
            end
            // collision: set on blocked write, same clear sequence
            if (collide) begin
                write_collision_flag_ff <= 1'h1;
            end else if (data_acc && stat_seen_ff) begin
                write_collision_flag_ff <= 1'h0;
            end
            // arm only when the returned status showed a flag up
            if (stat_rd && (prdata_ff[`SPIMS_S_DONE] ||
                prdata_ff[`SPIMS_S_WRITE_COLLISION_FLAG])) begin
                stat_seen_ff <= 1'h1;
            end else if (data_acc) begin
                stat_seen_ff <= 1'h0;
            end
            // mode fault: cleared by status read then control write
            if (fault) begin
                mode_fault_flag_ff <= 1'h1;
            end else if (ctrl_wr && mode_fault_flag_seen_ff) begin
                mode_fault_flag_ff <= 1'h0;
            end
            if (stat_rd && prdata_ff[`SPIMS_S_MODE_FAULT_FLAG]) begin
                mode_fault_flag_seen_ff <= 1'h1;
            end else if (ctrl_wr) begin
                mode_fault_flag_seen_ff <= 1'h0;
            end
        end
    end

    // transfer state: busy flag and bit counter
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            busy_ff <= 1'h0;
            cnt_ff <= 3'h0;
        end else if (fault || !port_en_ff) begin
            // disabled or faulted: abandon any byte
            busy_ff <= 1'h0;
            cnt_ff <= 3'h0;
        end else if (!master_ff && ss_n) begin
            // deselected slave drops a partial byte
            busy_ff <= 1'h0;
            cnt_ff <= 3'h0;
        end else if (last) begin
            busy_ff <= 1'h0;
            cnt_ff <= 3'h0;
        end else begin
            // master starts on an accepted write
            if (load && master_ff) begin
                busy_ff <= 1'h1;
            end
            // slave starts on the first clock edge
            if (s_lead) begin
                busy_ff <= 1'h1;
            end
            if (trail && busy_ff) begin
                cnt_ff <= cnt_ff + 3'h1;
            end
        end
    end

    // shift register and received byte buffer
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shr_ff <= `SPIMS_BYTE_RST;
            rbuf_ff <= `SPIMS_BYTE_RST;
        end else begin
            if (load) begin
                // parallel load from the bus
                shr_ff <= pwdata[7:0];
            end else if (samp && (busy_ff || s_lead)) begin
                // msb leaves first, new bit enters at lsb
                shr_ff <= {shr_ff[6:0], din};
            end
            if (last) begin
                rbuf_ff <= rx_byte;
            end
        end
    end

    // outgoing data bit
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_ff <= 1'h0;
        end else if (load) begin
            // phase zero needs the msb before the first edge
            out_ff <= pwdata[7];
        end else if (shift) begin
            out_ff <= shr_ff[7];
        end else if (!busy_ff) begin
            // idle: keep the msb ready for a selected slave
            out_ff <= shr_ff[7];
        end
    end

    // master clock generator; idles at the polarity level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_ff <= 1'h0;
        end else if (!run) begin
            sck_ff <= clock_polarity_bit_ff;
        end else if (tick) begin
            sck_ff <= ~sck_ff;
        end
    end

    // previous slave clock level for edge detection
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_prev_ff <= 1'h0;
        end else begin
            sck_prev_ff <= sck_in;
        end
    end

    // pins: master drives clock and mosi, slave drives miso
    assign sck_out = sck_ff;
    assign sck_oe = mst_on;
    assign mosi_out = out_ff;
    assign mosi_oe = mst_on;
    assign miso_out = out_ff;
    assign miso_oe = port_en_ff & ~master_ff & ~ss_n;

    // interrupt on done or mode fault when enabled
    assign irq = irq_en_ff & (done_ff | mode_fault_flag_ff);

endmodule // spims_top

// ---- test/spims_chk_sva.sv ----
// assertion checker for the serial master/slave port
`timescale 1ns/1ns
`include "spims_defs.vh"

module spims_chk #(
    parameter AW = 8
) (
    // apb side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [AW-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // serial side
    input wire ss_n,
    input wire sck_out,
    input wire sck_oe,
    input wire mosi_oe,
    input wire miso_oe,
    input wire irq
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire acc = psel && penable && pready; // completed transfer
    wire [5:0] idx = paddr[7:2]; // word index
    wire mapped = paddr[1:0] == 2'h0 && (idx == `SPIMS_CTRL_IDX ||
        idx == `SPIMS_STAT_IDX || idx == `SPIMS_DATA_IDX);
    wire ctl_wr = acc && pwrite && mapped && idx == `SPIMS_CTRL_IDX;
    wire dat_wr = acc && pwrite && mapped && idx == `SPIMS_DATA_IDX;
    reg ien_ff; // tracked interrupt enable
    reg [1:0] rate_ff; // tracked rate code
    reg prev_sck_ff; // clock one cycle back
    reg [4:0] gap_ff; // cycles since last clock change
    reg [4:0] tog_ff; // clock changes since start
    reg [4:0] half; // expected half period
    wire chg = sck_out != prev_sck_ff; // serial clock moved
    // half period per rate code
    always @* begin
        case (rate_ff)
            2'h0: half = 5'h01;
            2'h1: half = 5'h02;
            2'h2: half = 5'h08;
            default: half = 5'h10;
        endcase
    end
    // track control writes and clock edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien_ff <= 1'b0;
            rate_ff <= 2'h0;
            prev_sck_ff <= 1'b0;
            gap_ff <= 5'h00;
            tog_ff <= 5'h00;
        end else begin
            prev_sck_ff <= sck_out;
            gap_ff <= chg ? 5'h01 : gap_ff + 5'h01;
            if (ctl_wr) begin
                ien_ff <= pwdata[`SPIMS_C_IRQ_EN];
                rate_ff <= pwdata[1:0];
            end
            if (ctl_wr || dat_wr)
                tog_ff <= 5'h00;
            else if (chg && sck_oe)
                tog_ff <= tog_ff + 5'h01;
        end
    end
    miso_float_a: assert property (ss_n [*3] |-> !miso_oe)
        else $error("data out driven while deselected");
    slave_pins_a: assert property (miso_oe |-> !sck_oe && !mosi_oe)
        else $error("clock driven while slave");
    reset_pins_a: assert property ($rose(presetn) |->
        !sck_oe && !mosi_oe && !miso_oe)
        else $error("pins driven after reset");
    fault_drop_a: assert property (sck_oe && !ss_n |->
        ##[1:4] !sck_oe && !mosi_oe)
        else $error("master kept pins on select low");
    master_pair_a: assert property (sck_oe == mosi_oe)
        else $error("clock and data enables differ");
    rate_half_a: assert property (sck_oe && chg &&
        tog_ff != 5'h00 && tog_ff < 5'h10 |-> gap_ff == half)
        else $error("wrong serial clock half period");
    eight_bit_a: assert property (tog_ff <= 5'h10)
        else $error("more than eight clock pulses");
    map_err_a: assert property (psel && penable && !mapped |->
        pslverr)
        else $error("unmapped access not refused");
    map_ok_a: assert property (psel && penable && mapped |->
        !pslverr && prdata[31:8] == 24'h0)
        else $error("mapped access refused");
    irq_gate_a: assert property (irq |-> ien_ff)
        else $error("interrupt without enable");
    xfer_c: cover property (sck_oe && tog_ff == 5'h10);
    fault_c: cover property (sck_oe && !ss_n);
    slave_c: cover property (miso_oe);
    irq_c: cover property (irq);
endmodule // spims_chk

bind spims_top spims_chk #(.AW(AW)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ss_n(ss_n), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe), .irq(irq)
);

// ---- test/spims_peer.sv ----
// far-side serial peer: slave to the block or master to it
`timescale 1ns/1ns

module spims_peer (
    // timing reference
    input wire pclk,
    // resolved lines
    input wire sck_line,
    input wire mosi_line,
    input wire miso_line,
    // shared mode
    input wire clock_polarity_bit,
    input wire clock_phase_bit,
    input wire slave_on,
    // lines the peer drives
    output logic ss_n_o = 1'b1,
    output logic sck_o = 1'b0,
    output logic mosi_o = 1'b0,
    output logic miso_o = 1'b0,
    // last byte taken as slave
    output logic [7:0] rx_byte = 8'h00
);
    logic [7:0] sr_ff = 8'h00; // slave shift register
    int shifts_n = 0; // shift edges seen
    // released data out toggles each cycle
    always @(posedge pclk) begin
        if (!slave_on) miso_o <= ~miso_o;
    end
    // slave side: sample on one edge, shift on the other
    always @(sck_line) begin
        if (slave_on && sck_line === ~(clock_polarity_bit ^ clock_phase_bit)) begin
            rx_byte = {rx_byte[6:0], mosi_line};
        end else if (slave_on) begin
            if (!(clock_phase_bit && shifts_n == 0)) sr_ff = {sr_ff[6:0], ~sr_ff[0]};
            shifts_n++;
            miso_o = sr_ff[7];
        end
    end
    // load the answer byte
    task arm(input logic [7:0] b);
        @(posedge pclk);
        sr_ff <= b;
        miso_o <= b[7];
        shifts_n <= 0;
    endtask
    // drive select alone
    task set_sel(input logic v);
        @(posedge pclk);
        ss_n_o <= v;
    endtask
    // master frame, mode 0, four cycles a half period
    task send(input logic [7:0] b, input logic use_ss, output logic [7:0] got);
        got = 8'h00;
        @(posedge pclk);
        ss_n_o <= !use_ss;
        mosi_o <= b[7];
        repeat (4) @(posedge pclk);
        for (int i = 7; i >= 0; i--) begin
            sck_o <= 1'b1;
            got = {got[6:0], miso_line};
            repeat (4) @(posedge pclk);
            sck_o <= 1'b0;
            mosi_o <= (i > 0) ? b[i-1] : ~b[0];
            repeat (4) @(posedge pclk);
        end
        ss_n_o <= 1'b1;
    endtask
endmodule // spims_peer

// ---- test/testbench.sv ----
// self-checking bench for the serial master/slave port
`timescale 1ns/1ns
`include "spims_defs.vh"

module testbench;
    localparam logic [7:0] A_CTRL = {`SPIMS_CTRL_IDX, 2'h0};
    localparam logic [7:0] A_STAT = {`SPIMS_STAT_IDX, 2'h0};
    localparam logic [7:0] A_DATA = {`SPIMS_DATA_IDX, 2'h0};
    logic pclk = 1'b0; // bus clock
    logic presetn = 1'b0; // bus reset
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, sck_out, sck_oe, mosi_out, mosi_oe;
    wire miso_out, miso_oe, irq, p_ss_n, p_sck, p_mosi, p_miso;
    wire [7:0] p_rx; // byte the peer took
    logic clock_polarity_bit = 1'b0, clock_phase_bit = 1'b0, slave_on = 1'b0; // peer mode
    wire sck_w = sck_oe ? sck_out : p_sck; // resolved lines
    wire mosi_w = mosi_oe ? mosi_out : p_mosi;
    wire miso_w = miso_oe ? miso_out : p_miso;
    int num_errors = 0, checked = 0;
    logic [31:0] rd; // last read data
    logic err; // last error response
    spims_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ss_n(p_ss_n),
        .sck_in(sck_w), .sck_out(sck_out), .sck_oe(sck_oe),
        .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
        .miso_in(miso_w), .miso_out(miso_out), .miso_oe(miso_oe), .irq(irq)
    );
    spims_peer u_peer (
        .pclk(pclk), .sck_line(sck_w), .mosi_line(mosi_w),
        .miso_line(miso_w), .clock_polarity_bit(clock_polarity_bit), .clock_phase_bit(clock_phase_bit), .slave_on(slave_on),
        .ss_n_o(p_ss_n), .sck_o(p_sck), .mosi_o(p_mosi), .miso_o(p_miso),
        .rx_byte(p_rx)
    );
    initial begin
        forever #10 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer, setup then access until ready
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // poll status until the done flag shows
    task wait_done;
        rd = 32'h0;
        for (int n = 0; n < 200 && rd[7] !== 1'b1; n++) apb(1'b0, A_STAT, 0);
    endtask
    task t_reset;
        rdc(A_CTRL, 32'h0);
        rdc(A_STAT, 32'h0);
        rdc(A_DATA, 32'h0);
        chk({sck_oe, mosi_oe, miso_oe}, 32'h0);
        apb(1'b1, 8'h29, 32'hFF);
        chk(err, 1'b1);
        apb(1'b0, 8'h34, 32'h0);
        chk({err, rd[7:0]}, 32'h100);
        rdc(A_CTRL, 32'h0);
        $display("reset test done");
    endtask
    // master byte in mode m at rate code m
    task t_master(input int m);
        logic [7:0] c, tx, ans;
        c = {m == 1, 3'b101, m[1], m[0], m[1:0]};
        tx = 8'hA5 - m[7:0];
        ans = 8'h3C + m[7:0];
        slave_on <= 1'b1;
        clock_polarity_bit <= m[1];
        clock_phase_bit <= m[0];
        apb(1'b1, A_CTRL, {24'h0, c});
        repeat (2) @(negedge pclk);
        chk(sck_out, m[1]);
        u_peer.arm(ans);
        apb(1'b1, A_DATA, {24'h0, tx});
        wait_done;
        chk(rd, 32'h80);
        chk(irq, m == 1);
        rdc(A_DATA, {24'h0, ans});
        chk(p_rx, tx);
        chk(sck_out, m[1]);
        rdc(A_STAT, 32'h0);
        chk(irq, 1'b0);
        $display("master test %0d done", m);
    endtask
    task t_fault;
        slave_on <= 1'b0;
        apb(1'b1, A_CTRL, 32'h50);
        @(negedge pclk);
        chk({sck_oe, mosi_oe}, 32'h3);
        u_peer.set_sel(1'b0);
        repeat (4) @(negedge pclk);
        chk({sck_oe, mosi_oe, miso_oe}, 32'h0);
        rdc(A_CTRL, 32'h0);
        rdc(A_STAT, 32'h10);
        u_peer.set_sel(1'b1);
        apb(1'b1, A_CTRL, 32'h0);
        rdc(A_STAT, 32'h0);
        $display("fault test done");
    endtask
    task t_slave;
        logic [7:0] got;
        clock_polarity_bit <= 1'b0;
        clock_phase_bit <= 1'b0;
        apb(1'b1, A_CTRL, 32'h43);
        apb(1'b1, A_DATA, 32'h96);
        u_peer.send(8'hFF, 1'b0, got);
        chk(miso_oe, 1'b0);
        rdc(A_STAT, 32'h0);
        u_peer.set_sel(1'b0);
        repeat (4) @(negedge pclk);
        chk({miso_oe, miso_out}, 32'h3);
        apb(1'b1, A_DATA, 32'h11);
        rdc(A_STAT, 32'h40);
        u_peer.send(8'h5A, 1'b1, got);
        chk(got, 8'h96);
        rdc(A_STAT, 32'hC0);
        rdc(A_DATA, 32'h5A);
        rdc(A_STAT, 32'h0);
        $display("slave test done");
    endtask
    task conclude;
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        for (int m = 0; m < 4; m++) t_master(m);
        t_fault;
        t_slave;
        conclude;
    end
    // cut a hang short
    initial begin
        #200000;
        num_errors++;
        $display("watchdog expired at %0t", $time);
        conclude;
    end
endmodule // testbench
